// File: shared/tdc_cfg_regs.vh
// offsets, field positions, defaults and command codes of the config set
`ifndef TDC_CFG_REGS_VH
`define TDC_CFG_REGS_VH

// ---------------------------------------------------------------------
// register set geometry
// ---------------------------------------------------------------------
`define CFG_WORDS 7
`define CFG_WORD_W 32
`define CFG_ADDR_W 3
`define CFG_LAST_ADDR 3'h6

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define ID_MSB 7
`define ID_LSB 0
`define DELAY_MSB 23
`define DELAY_LSB 8
`define HIT_ONE_MSB 27
`define HIT_ONE_LSB 24
`define HIT_TWO_MSB 31
`define HIT_TWO_LSB 28
`define FIRST_WAVE_BIT 30
`define AUTO_CALC_BIT 31
`define TOP_BYTE_MSB 31
`define TOP_BYTE_LSB 24

// ---------------------------------------------------------------------
// reset values of the seven words
// ---------------------------------------------------------------------
`define CFG0_DEFAULT 32'h22022000
`define CFG1_DEFAULT 32'h55000000
`define CFG2_DEFAULT 32'h20000000
`define CFG3_DEFAULT 32'h00000000
`define CFG4_DEFAULT 32'h00000000
`define CFG5_DEFAULT 32'h00000000
`define CFG6_DEFAULT 32'h00000000

// ---------------------------------------------------------------------
// serial command bytes and the link check read address
// ---------------------------------------------------------------------
`define OP_WRITE_HEAD 5'h10
`define OP_READ_HEAD 5'h16
`define OP_POWER_RESET 8'h50
`define LINK_CHECK_ADDR 3'h5
`define LINK_CHECK_SRC 1

`endif

// File: core/spi_frame_shifter.v
// serial byte engine: clock idle low, drive at rise, sample at fall
`timescale 1ns/100ps
`default_nettype none

module spi_frame_shifter (
	input wire clk,
	input wire nrst,
	input wire slave_select_n,
	input wire serial_clock,
	input wire serial_in,
	input wire [7:0] tx_byte,
	input wire tx_load,
	output reg [7:0] rx_byte,
	output reg byte_done,
	output reg serial_out
);

	reg sck_prev;
	reg [2:0] bit_cnt;
	reg [7:0] rx_shift;
	reg [7:0] tx_shift;
	wire sck_rise;
	wire sck_fall;

	// edges seen in the system clock; pins are taken as synchronous
	assign sck_rise = serial_clock & ~sck_prev;
	assign sck_fall = ~serial_clock & sck_prev;

	// -----------------------------------------------------------------
	// shifting
	// -----------------------------------------------------------------
	// frame ends drop any partial byte so a torn frame cannot commit
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sck_prev <= 1'b0;
			bit_cnt <= 3'h0;
			rx_shift <= 8'h00;
			tx_shift <= 8'h00;
			rx_byte <= 8'h00;
			byte_done <= 1'b0;
			serial_out <= 1'b0;
		end else begin
			sck_prev <= serial_clock;
			byte_done <= 1'b0;
			if (slave_select_n) begin
				bit_cnt <= 3'h0;
				tx_shift <= 8'h00;
				serial_out <= 1'b0;
			end else begin
				if (tx_load) begin
					tx_shift <= tx_byte;
				end else if (sck_rise) begin // see (RL9)
					serial_out <= tx_shift[7];
					tx_shift <= {tx_shift[6:0], 1'b0};
				end
				if (sck_fall) begin // see (RL9)
					rx_shift <= {rx_shift[6:0], serial_in};
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == 3'h7) begin
						rx_byte <= {rx_shift[6:0], serial_in};
						byte_done <= 1'b1;
					end
				end
			end
		end
	end

endmodule

`default_nettype wire

// File: core/tdc_config_register_set.v
// configuration register set of the time-to-digital converter
// Function
// (RL1) seven 32-bit configuration words, numbered 0 to 6, set the mode.
// (RL2) the upper 24 bits of each word are writable but never read back; the code reads the word 1 top byte back at address 5.
// (RL3) the low byte of each word is a free identifier, written and read; the word 5 low byte is never read, address 5 gives the word 1 top byte.
// (RL4) a read at address 5 returns the top byte held in word 1.
// (RL5) word 3 bits 30 and 31 enable extras; bit 30 selects first wave.
// (RL6) in first-wave mode the second and third delay fields change meaning.
// (RL7) the host resets the part by pin or command after power-up.
// (RL8) fields sit at their listed bit positions with listed defaults.
// (RL9) serial link: clock idle low, phase one, low-active slave select.
// (RL10) any reset loads every field default, other bits zero.
`timescale 1ns/100ps
`default_nettype none
`include "tdc_cfg_regs.vh"

module tdc_config_register_set (
	input wire clk,
	input wire nrst,
	input wire reset_pin_n,
	input wire slave_select_n,
	input wire serial_clock,
	input wire serial_in,
	output wire serial_out,
	output wire serial_out_en,
	output wire [31:0] config_word_0,
	output wire [31:0] config_word_1,
	output wire [31:0] config_word_2,
	output wire [31:0] config_word_3,
	output wire [31:0] config_word_4,
	output wire [31:0] config_word_5,
	output wire [31:0] config_word_6,
	output wire first_wave_enable,
	output wire auto_calc_enable,
	output wire [3:0] hit_selector_one,
	output wire [3:0] hit_selector_two,
	output wire [7:0] id_byte_one,
	output wire [15:0] stop_delay_value_one,
	output wire [15:0] stop_delay_value_two,
	output wire [15:0] stop_delay_value_three,
	output wire [15:0] wave_param_two,
	output wire [15:0] wave_param_three
);

	// -----------------------------------------------------------------
	// states and command kinds
	// -----------------------------------------------------------------
	localparam ST_OPCODE = 2'h0;
	localparam ST_WRITE = 2'h1;
	localparam ST_READ = 2'h2;
	localparam ST_SKIP = 2'h3;
	localparam OP_NONE = 2'h0;
	localparam OP_WRITE = 2'h1;
	localparam OP_READ = 2'h2;
	localparam OP_RESET = 2'h3;

	wire [31:0] cfg [0:`CFG_WORDS-1];
	reg [1:0] state;
	reg [1:0] byte_idx;
	reg [2:0] wr_addr;
	reg [31:0] wr_shift;
	reg commit;
	reg cmd_reset;
	reg [7:0] tx_byte;
	wire [7:0] rx_byte;
	wire byte_done;
	wire tx_load;
	wire soft_reset;

	// -----------------------------------------------------------------
	// decoding helpers
	// -----------------------------------------------------------------
	// classify a command byte; out-of-range word numbers are ignored on writes only
	function [1:0] op_kind;
		input [7:0] b;
		begin
			if (b == `OP_POWER_RESET)
				op_kind = OP_RESET;
			else if (b[7:3] == `OP_WRITE_HEAD && b[2:0] <= `CFG_LAST_ADDR)
				op_kind = OP_WRITE;
			else if (b[7:3] == `OP_READ_HEAD)
				op_kind = OP_READ;
			else
				op_kind = OP_NONE;
		end
	endfunction

	// reset value of each word
	function [31:0] default_word;
		input integer idx;
		begin
			case (idx)
				0: default_word = `CFG0_DEFAULT;
				1: default_word = `CFG1_DEFAULT;
				2: default_word = `CFG2_DEFAULT;
				3: default_word = `CFG3_DEFAULT;
				4: default_word = `CFG4_DEFAULT;
				5: default_word = `CFG5_DEFAULT;
				6: default_word = `CFG6_DEFAULT;
				default: default_word = 32'h00000000;
			endcase
		end
	endfunction

	// -----------------------------------------------------------------
	// serial engine
	// -----------------------------------------------------------------
	spi_frame_shifter u_shifter (
		.clk(clk),
		.nrst(nrst),
		.slave_select_n(slave_select_n),
		.serial_clock(serial_clock),
		.serial_in(serial_in),
		.tx_byte(tx_byte),
		.tx_load(tx_load),
		.rx_byte(rx_byte),
		.byte_done(byte_done),
		.serial_out(serial_out)
	);

	// driven only inside a frame so the line stays free for others
	assign serial_out_en = ~slave_select_n; // see (RL9)

	// pin reset and reset command share one default load
	assign soft_reset = ~reset_pin_n | cmd_reset; // see (RL7)

	// -----------------------------------------------------------------
	// read-back selection
	// -----------------------------------------------------------------
	// only low bytes leave the part, except the link check path
	assign tx_load = byte_done & (state == ST_OPCODE);
	always @* begin
		tx_byte = 8'h00;
		if (op_kind(rx_byte) == OP_READ) begin
			if (rx_byte[2:0] == `LINK_CHECK_ADDR)
				tx_byte = cfg[`LINK_CHECK_SRC][`TOP_BYTE_MSB:`TOP_BYTE_LSB]; // see (RL4)
			else if (rx_byte[2:0] <= `CFG_LAST_ADDR)
				tx_byte = cfg[rx_byte[2:0]][`ID_MSB:`ID_LSB]; // see (RL2) (RL3)
		end
	end

	// -----------------------------------------------------------------
	// command sequencer
	// -----------------------------------------------------------------
	// a write commits only after all four bytes, msb first
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_OPCODE;
			byte_idx <= 2'h0;
			wr_addr <= 3'h0;
			wr_shift <= 32'h00000000;
			commit <= 1'b0;
			cmd_reset <= 1'b0;
		end else if (slave_select_n || !reset_pin_n) begin
			state <= ST_OPCODE;
			byte_idx <= 2'h0;
			commit <= 1'b0;
			cmd_reset <= 1'b0;
		end else begin
			commit <= 1'b0;
			cmd_reset <= 1'b0;
			if (byte_done) begin
				case (state)
					ST_OPCODE: begin
						byte_idx <= 2'h0;
						wr_addr <= rx_byte[2:0];
						case (op_kind(rx_byte))
							OP_WRITE: state <= ST_WRITE;
							OP_READ: state <= ST_READ;
							OP_RESET: begin
								cmd_reset <= 1'b1; // see (RL7)
								state <= ST_SKIP;
							end
							default: state <= ST_SKIP;
						endcase
					end
					ST_WRITE: begin
						wr_shift <= {wr_shift[23:0], rx_byte};
						byte_idx <= byte_idx + 2'h1;
						if (byte_idx == 2'h3) begin
							commit <= 1'b1;
							state <= ST_SKIP;
						end
					end
					ST_READ: state <= ST_READ;
					ST_SKIP: state <= ST_SKIP;
					default: state <= ST_SKIP;
				endcase
			end
		end
	end

	// -----------------------------------------------------------------
	// the seven words
	// -----------------------------------------------------------------
	// full 32-bit storage; upper bits reach the core, the link only as the word 1 top byte read at address 5
	genvar gi;
	generate
		for (gi = 0; gi < `CFG_WORDS; gi = gi + 1) begin : g_word
			reg [31:0] word;
			// one register per word so each has a single driver
			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					word <= default_word(gi); // see (RL10) (RL8)
				end else if (soft_reset) begin
					word <= default_word(gi); // see (RL10)
				end else if (commit && wr_addr == gi) begin
					word <= wr_shift; // see (RL1) (RL2) (RL3)
				end
			end
			// the array is only a read view of the word registers
			assign cfg[gi] = word;
		end
	endgenerate

	assign config_word_0 = cfg[0];
	assign config_word_1 = cfg[1];
	assign config_word_2 = cfg[2];
	assign config_word_3 = cfg[3];
	assign config_word_4 = cfg[4];
	assign config_word_5 = cfg[5];
	assign config_word_6 = cfg[6];

	// -----------------------------------------------------------------
	// decoded fields
	// -----------------------------------------------------------------
	// named fields for the measurement engines
	assign hit_selector_one = cfg[1][`HIT_ONE_MSB:`HIT_ONE_LSB]; // see (RL8)
	assign hit_selector_two = cfg[1][`HIT_TWO_MSB:`HIT_TWO_LSB]; // see (RL8)
	assign id_byte_one = cfg[1][`ID_MSB:`ID_LSB]; // see (RL8)
	assign stop_delay_value_one = cfg[2][`DELAY_MSB:`DELAY_LSB]; // see (RL8)
	assign first_wave_enable = cfg[3][`FIRST_WAVE_BIT]; // see (RL5)
	assign auto_calc_enable = cfg[3][`AUTO_CALC_BIT]; // see (RL5)

	// one field, two meanings; the unused view reads zero so an
	// engine never uses a value meant for the other mode
	assign stop_delay_value_two = first_wave_enable ? 16'h0000 :
		cfg[3][`DELAY_MSB:`DELAY_LSB]; // see (RL6)
	assign stop_delay_value_three = first_wave_enable ? 16'h0000 :
		cfg[4][`DELAY_MSB:`DELAY_LSB]; // see (RL6)
	assign wave_param_two = first_wave_enable ?
		cfg[3][`DELAY_MSB:`DELAY_LSB] : 16'h0000; // see (RL6)
	assign wave_param_three = first_wave_enable ?
		cfg[4][`DELAY_MSB:`DELAY_LSB] : 16'h0000; // see (RL6)

endmodule

`default_nettype wire

// File: testbench/tdc_config_register_set_chk.sv
// port checker of the configuration register set
`timescale 1ns/100ps
`default_nettype none
module tdc_cfg_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic reset_pin_n,
	input wire logic slave_select_n,
	input wire logic serial_clock,
	input wire logic serial_out,
	input wire logic serial_out_en,
	input wire logic [31:0] config_word_0,
	input wire logic [31:0] config_word_1,
	input wire logic [31:0] config_word_2,
	input wire logic [31:0] config_word_3,
	input wire logic [31:0] config_word_4,
	input wire logic first_wave_enable,
	input wire logic auto_calc_enable,
	input wire logic [3:0] hit_selector_one,
	input wire logic [3:0] hit_selector_two,
	input wire logic [7:0] id_byte_one,
	input wire logic [15:0] stop_delay_value_one,
	input wire logic [15:0] stop_delay_value_two,
	input wire logic [15:0] stop_delay_value_three,
	input wire logic [15:0] wave_param_two,
	input wire logic [15:0] wave_param_three
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// link idle and pin reset released long enough for any commit to land
	sequence quiet;
		(slave_select_n && reset_pin_n)[*4];
	endsequence
	// a rise of the serial clock one or two cycles back
	sequence sck_rose;
		$past(serial_clock) && (!$past(serial_clock, 2) || !$past(serial_clock, 3));
	endsequence
	a_fw_view: assert property (first_wave_enable |-> stop_delay_value_two == 16'h0 && wave_param_three == config_word_4[23:8]) else $error("first wave view wrong");
	a_normal_view: assert property (!first_wave_enable |-> stop_delay_value_three == config_word_4[23:8] && wave_param_two == 16'h0) else $error("delay view wrong");
	a_field_map: assert property (hit_selector_one == config_word_1[27:24] && hit_selector_two == config_word_1[31:28] && id_byte_one == config_word_1[7:0] && stop_delay_value_one == config_word_2[23:8]) else $error("field map wrong");
	a_mode_bits: assert property (first_wave_enable == config_word_3[30] && auto_calc_enable == config_word_3[31]) else $error("mode bits wrong");
	a_pin_reset: assert property (!reset_pin_n |=> config_word_0 == 32'h22022000 && config_word_1 == 32'h55000000 && config_word_3 == 32'h0) else $error("pin reset defaults wrong");
	a_out_enable: assert property (serial_out_en == !slave_select_n) else $error("output enable wrong");
	a_out_idle: assert property (slave_select_n[*2] |-> !serial_out) else $error("data out not idle");
	a_words_hold: assert property (quiet |-> $stable(config_word_1) && $stable(config_word_3)) else $error("word changed while idle");
	a_out_timing: assert property ($changed(serial_out) && !slave_select_n && !$past(slave_select_n) |-> sck_rose) else $error("data out moved off clock rise");
endmodule
bind tdc_config_register_set tdc_cfg_chk chk (.*);
`default_nettype wire

// File: testbench/spi_host_model.sv
// host side serial master model
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
	input wire logic clk,
	output logic slave_select_n,
	output logic serial_clock,
	output logic serial_in,
	input wire logic serial_out
);
	initial begin
		slave_select_n = 1'b1;
		serial_clock = 1'b0;
		serial_in = 1'b0;
	end
	// released data line toggles so a stale bit never looks like data
	always @(posedge clk) begin
		if (slave_select_n) begin
			serial_in <= ~serial_in;
		end
	end
	// one frame, msb first, clock idle low, data taken at the fall
	task automatic xfer(input logic [39:0] d, input int n, output logic [7:0] rd);
		rd = 8'h00;
		@(posedge clk);
		slave_select_n <= 1'b0;
		// first bit a cycle later so the idle toggle never races it
		@(posedge clk);
		for (int i = 0; i < n; i++) begin
			serial_in <= d[39 - i];
			@(posedge clk);
			serial_clock <= 1'b1;
			repeat (2) @(posedge clk);
			@(negedge clk);
			rd = {rd[6:0], serial_out};
			@(posedge clk);
			serial_clock <= 1'b0;
			repeat (2) @(posedge clk);
		end
		// leave room for the commit before ending the frame
		repeat (2) @(posedge clk);
		slave_select_n <= 1'b1;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// File: testbench/tdc_config_register_set_test.sv
// self-checking bench of the configuration register set
`timescale 1ns/100ps
`default_nettype none
`include "tdc_cfg_regs.vh"
module tdc_config_register_set_test;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic reset_pin_n = 1'b1;
	logic sel_n, sck, sdi, sdo, sdo_en, fwe, ace;
	logic [6:0][31:0] w;
	logic [31:0] dflt [7] = '{`CFG0_DEFAULT, `CFG1_DEFAULT, `CFG2_DEFAULT,
		`CFG3_DEFAULT, `CFG4_DEFAULT, `CFG5_DEFAULT, `CFG6_DEFAULT};
	logic [31:0] mdl [7];
	logic [31:0] seed = 32'h5d;
	logic [31:0] v;
	logic [7:0] rd;
	logic [15:0] d2, d3, p2, p3;
	int checked = 0;
	int n_mismatch = 0;
	int cycles = 0;
	always #50 clk = ~clk;
	spi_host_model host (.clk(clk), .slave_select_n(sel_n), .serial_clock(sck),
		.serial_in(sdi), .serial_out(sdo));
	tdc_config_register_set dut (.clk(clk), .nrst(nrst),
		.reset_pin_n(reset_pin_n), .slave_select_n(sel_n), .serial_clock(sck),
		.serial_in(sdi), .serial_out(sdo), .serial_out_en(sdo_en),
		.config_word_0(w[0]), .config_word_1(w[1]), .config_word_2(w[2]),
		.config_word_3(w[3]), .config_word_4(w[4]), .config_word_5(w[5]),
		.config_word_6(w[6]), .first_wave_enable(fwe), .auto_calc_enable(ace),
		.hit_selector_one(), .hit_selector_two(), .id_byte_one(),
		.stop_delay_value_one(), .stop_delay_value_two(d2),
		.stop_delay_value_three(d3), .wave_param_two(p2),
		.wave_param_three(p3));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// only the low byte reads back; address 5 shows word 1 top byte
	function automatic logic [31:0] exp_rd(input int n);
		if (n == 5) return {24'h0, mdl[1][31:24]};
		if (n == 7) return 32'h0;
		return {24'h0, mdl[n][7:0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_all();
		for (int i = 0; i < 7; i++) chk(w[i], mdl[i]);
	endtask
	task automatic end_of_test();
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// hang guard, a full run needs well under this many cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		mdl = dflt;
		chk_all();
		// write every address, address 7 included, then read it back
		for (int n = 0; n < 8; n++) begin
			v = rnd();
			if (n == 3) v[30] = 1'b1;
			host.xfer({`OP_WRITE_HEAD, n[2:0], v}, 40, rd);
			if (n < 7) mdl[n] = v;
			chk_all();
			host.xfer({`OP_READ_HEAD, n[2:0], 32'h0}, 16, rd);
			chk({24'h0, rd}, exp_rd(n));
		end
		chk({31'h0, fwe}, 32'h1);
		chk({16'h0, p2}, {16'h0, mdl[3][23:8]});
		chk({16'h0, d2}, 32'h0);
		v = rnd() & 32'hbfffffff;
		host.xfer({`OP_WRITE_HEAD, 3'h3, v}, 40, rd);
		mdl[3] = v;
		chk({16'h0, d2}, {16'h0, v[23:8]});
		chk({16'h0, p2}, 32'h0);
		// a frame cut short must not commit
		host.xfer({`OP_WRITE_HEAD, 3'h2, rnd()}, 24, rd);
		chk_all();
		host.xfer({`OP_POWER_RESET, 32'h0}, 8, rd);
		mdl = dflt;
		chk_all();
		host.xfer({`OP_READ_HEAD, 3'h5, 32'h0}, 16, rd);
		chk({24'h0, rd}, 32'h55);
		host.xfer({`OP_WRITE_HEAD, 3'h1, rnd()}, 40, rd);
		reset_pin_n <= 1'b0;
		@(posedge clk);
		reset_pin_n <= 1'b1;
		// idle long enough for the hold check on quiet words to engage
		repeat (8) @(posedge clk);
		chk_all();
		end_of_test();
	end
endmodule
`default_nettype wire
